// File: design/rtc_backup_power_control.sv
// backup/normal switchover, compensation pacing and interrupt output
//
// Behaviour
// [RULE_01] compensation interval picked by two-bit field
// [RULE_02] interval field loads 01 at power-up
// [RULE_03] compensation resumes once supply above threshold
// [RULE_04] one active-low interrupt for three sources
// [RULE_05] host reads event flags to find source
// [RULE_06] host clears enables when interrupt unused
// [RULE_07] backup: switch off, detector sampled each second
// [RULE_08] cold start in backup, first sample after 1s
// [RULE_09] backup: detector low-to-high enters normal
// [RULE_10] normal: switch opened each second for sampling
// [RULE_11] normal: detected supply drop enters backup
// [RULE_12] switch opened by detection, no reverse current
// [RULE_13] switch stays on until next sample
// [RULE_14] backup: host serial interface disabled
// [RULE_15] backup: events kept, interrupt held inactive
// [RULE_16] backup: no frequency output
// [RULE_17] sample field sets window; disable bit overrides
// [RULE_18] ticks derived from internal timebase
`timescale 1ns/1ps
`default_nettype none
module rtc_backup_power_control
    import rtc_pwr_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = MS_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       main_supply_detector,
    input  wire logic       comp_threshold_voltage,
    input  wire logic       timer_event,
    input  wire logic       alarm_event,
    input  wire logic       update_event,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata_q,
    output logic            monitor_on_q,
    output logic            supply_switch_on_q,
    output logic            normal_state_q,
    output logic            serial_if_enable_q,
    output logic            freq_out_enable_q,
    output logic            comp_run_q,
    output logic            int_n_o_q,
    output logic            int_n_oe_q
);
    ////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [14:0] comp_limit(input logic [1:0] sel);
        unique case (sel)
            2'b00: comp_limit = 15'(COMP_T0_MS - 1);
            2'b01: comp_limit = 15'(COMP_T1_MS - 1);
            2'b10: comp_limit = 15'(COMP_T2_MS - 1);
            2'b11: comp_limit = 15'(COMP_T3_MS - 1);
        endcase
    endfunction : comp_limit

    function automatic logic [8:0] win_limit(input logic [1:0] sel);
        unique case (sel)
            2'b00: win_limit = 9'(SMP_T0_MS - 1);
            2'b01: win_limit = 9'(SMP_T1_MS - 1);
            2'b10: win_limit = 9'(SMP_T2_MS - 1);
            2'b11: win_limit = 9'(SMP_T3_MS - 1);
        endcase
    endfunction : win_limit

    ////////////////////////////////////////////////////////////////////
    // timebase

    logic ms_tick;
    logic sec_tick;

    ms_timebase #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timebase (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .ms_tick  (ms_tick),
        .sec_tick (sec_tick)
    ); // RULE_18

    ////////////////////////////////////////////////////////////////////
    // registers

    pwr_state_e state_q;
    logic [7:0] ctrl_q;
    logic [7:0] bkup_q;
    logic       upd_flag_q;
    logic       tmr_flag_q;
    logic       alm_flag_q;
    logic       drop_flag_q;
    logic       in_backup;
    logic       host_wr;
    logic       wr_flag;
    logic [1:0] comp_interval;
    logic       update_irq_enable;
    logic       timer_irq_enable;
    logic       alarm_irq_enable;
    logic       detector_disable;
    logic       switch_force_off;
    logic [1:0] sample_time;

    assign in_backup         = (state_q == ST_BACKUP);
    // a powered-down interface takes no writes
    assign host_wr           = reg_wr && !in_backup; // RULE_14
    assign wr_flag           = host_wr && (reg_addr == ADDR_FLAG);
    assign comp_interval     = ctrl_q[CTRL_CSEL +: 2];
    assign update_irq_enable = ctrl_q[CTRL_UIE];
    assign timer_irq_enable  = ctrl_q[CTRL_TIE];
    assign alarm_irq_enable  = ctrl_q[CTRL_AIE];
    assign detector_disable  = bkup_q[BK_DDIS];
    assign switch_force_off  = bkup_q[BK_SWITCH_FORCE_OFF];
    assign sample_time       = bkup_q[BK_SMP +: 2];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RESET; // RULE_02
            bkup_q <= BK_RESET;
        end else if (host_wr) begin
            if (reg_addr == ADDR_CTRL) begin
                ctrl_q <= reg_wdata & CTRL_WMASK;
            end
            if (reg_addr == ADDR_BKUP) begin
                bkup_q <= reg_wdata & BK_WMASK;
            end
        end
    end

    // flags keep latching events in backup; a new event beats a same-cycle clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            upd_flag_q  <= 1'b0;
            tmr_flag_q  <= 1'b0;
            alm_flag_q  <= 1'b0;
            drop_flag_q <= 1'b0;
        end else begin
            upd_flag_q  <= update_event
                         | (upd_flag_q & !(wr_flag & !reg_wdata[FLAG_UPD]));
            tmr_flag_q  <= timer_event
                         | (tmr_flag_q & !(wr_flag & !reg_wdata[FLAG_TMR]));
            alm_flag_q  <= alarm_event
                         | (alm_flag_q & !(wr_flag & !reg_wdata[FLAG_ALM]));
            drop_flag_q <= !comp_threshold_voltage
                         | (drop_flag_q & !(wr_flag & !reg_wdata[FLAG_DROP]));
        end
    end // RULE_15

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 8'h00;
        end else if (in_backup) begin
            reg_rdata_q <= 8'h00; // RULE_14
        end else begin
            unique case (reg_addr)
                ADDR_FLAG: reg_rdata_q <= {2'b00, upd_flag_q, tmr_flag_q,
                                           alm_flag_q, 2'b00, drop_flag_q};
                ADDR_CTRL: reg_rdata_q <= ctrl_q;
                ADDR_BKUP: reg_rdata_q <= bkup_q;
                default:   reg_rdata_q <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // supply sampling window

    logic       win_q;
    logic [8:0] win_cnt_q;
    logic       win_start;
    logic       win_end;
    logic       det_prev_q;
    logic [8:0] win_lim;

    // in normal with the detector disabled nothing is sampled
    assign win_start = sec_tick && !win_q
                     && (in_backup || !detector_disable); // RULE_07 RULE_10
    // a window shortened mid-way still closes at the next tick
    assign win_lim   = win_limit(sample_time);
    assign win_end   = win_q && ms_tick
                     && (win_cnt_q >= win_lim); // RULE_17

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            win_q     <= 1'b0;
            win_cnt_q <= '0;
        end else if (win_start) begin
            win_q     <= 1'b1;
            win_cnt_q <= '0;
        end else if (win_end) begin
            win_q     <= 1'b0;
        end else if (win_q && ms_tick) begin
            win_cnt_q <= win_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power state

    // detector is only trusted at the close of a window
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= ST_BACKUP; // RULE_08
            det_prev_q <= 1'b0;
        end else if (win_end) begin
            det_prev_q <= main_supply_detector;
            unique case (state_q)
                ST_BACKUP: begin
                    if (main_supply_detector && !det_prev_q) begin
                        state_q <= ST_NORMAL; // RULE_09
                    end
                end
                ST_NORMAL: begin
                    if (!main_supply_detector) begin
                        state_q <= ST_BACKUP; // RULE_11
                    end
                end
            endcase
        end
    end

    // switch follows state and window; a dead supply keeps it on until
    // the next window opens, up to about a second unless the detector is disabled
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            supply_switch_on_q <= 1'b0;
            monitor_on_q       <= 1'b0;
            normal_state_q     <= 1'b0;
        end else begin
            supply_switch_on_q <= !in_backup && !win_q
                                && !(detector_disable && switch_force_off);
            monitor_on_q       <= win_q; // RULE_17
            normal_state_q     <= !in_backup;
        end
    end // RULE_12 RULE_13 RULE_07

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            serial_if_enable_q <= 1'b0;
            freq_out_enable_q  <= 1'b0;
        end else begin
            serial_if_enable_q <= !in_backup; // RULE_14
            freq_out_enable_q  <= !in_backup; // RULE_16
        end
    end

    ////////////////////////////////////////////////////////////////////
    // temperature compensation pacing

    logic [14:0] comp_cnt_q;
    logic [14:0] comp_lim;
    logic        comp_due;
    logic        ctrl_ivl_wr;

    // a new interval restarts the count so it never overshoots the limit
    assign ctrl_ivl_wr = host_wr && (reg_addr == ADDR_CTRL)
                       && (reg_wdata[CTRL_CSEL +: 2] != comp_interval);
    assign comp_lim    = comp_limit(comp_interval);
    assign comp_due    = ms_tick && (comp_cnt_q >= comp_lim);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            comp_cnt_q <= '0;
            comp_run_q <= 1'b0;
        end else begin
            // a due slot below threshold is skipped, not deferred
            comp_run_q <= comp_due && comp_threshold_voltage; // RULE_03
            if (comp_due) begin
                comp_cnt_q <= '0; // RULE_01
            end else if (ctrl_ivl_wr) begin
                comp_cnt_q <= '0; // RULE_01
            end else if (ms_tick) begin
                comp_cnt_q <= comp_cnt_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shared interrupt output (open drain, drives low only)

    logic int_req;

    assign int_req = (upd_flag_q && update_irq_enable)
                   || (tmr_flag_q && timer_irq_enable)
                   || (alm_flag_q && alarm_irq_enable); // RULE_04

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            int_n_o_q  <= 1'b0;
            int_n_oe_q <= 1'b0;
        end else begin
            int_n_o_q  <= 1'b0;
            int_n_oe_q <= int_req && !in_backup; // RULE_04 RULE_15
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    a_int_backup_off: assert property (
        in_backup |=> !int_n_oe_q) // RULE_15
        else $error("interrupt driven in backup");

    a_int_has_cause: assert property (
        int_n_oe_q |-> $past(int_req) && !$past(in_backup)) // RULE_04
        else $error("interrupt without enabled flag");

    a_tmr_flag_set: assert property (
        timer_event |=> tmr_flag_q) // RULE_15
        else $error("timer event lost");

    a_switch_backup: assert property (
        in_backup |=> !supply_switch_on_q) // RULE_07
        else $error("switch on in backup");

    a_switch_win: assert property (
        win_q |=> !supply_switch_on_q && monitor_on_q) // RULE_10
        else $error("switch on during sample window");

    a_to_normal: assert property (
        in_backup && win_end && main_supply_detector && !det_prev_q
        |=> state_q == ST_NORMAL) // RULE_09
        else $error("missed return to normal");

    a_to_backup: assert property (
        !in_backup && win_end && !main_supply_detector
        |=> in_backup ##1 !supply_switch_on_q) // RULE_11
        else $error("missed drop to backup");

    a_if_off: assert property (
        in_backup |=> !serial_if_enable_q && !freq_out_enable_q
                      && reg_rdata_q == 8'h00) // RULE_14
        else $error("interface or output active in backup");

    a_comp_gate: assert property (
        comp_run_q |-> $past(comp_threshold_voltage)
                       && $past(comp_cnt_q) == $past(comp_lim)) // RULE_01
        else $error("compensation outside its slot");

    a_win_len: assert property (
        $fell(win_q) |-> $past(ms_tick)
                         && $past(win_cnt_q) >= $past(win_lim)) // RULE_17
        else $error("window closed before its length");

    a_no_win_ddis: assert property (
        !in_backup && detector_disable && !win_q |=> !win_q) // RULE_17
        else $error("window opened with detector disabled");

    c_enter_normal: cover property (
        in_backup ##1 !in_backup);
    c_enter_backup: cover property (
        !in_backup ##1 in_backup);
    c_int_low: cover property (
        $rose(int_n_oe_q));
    c_comp_run: cover property (
        comp_run_q);
endmodule : rtc_backup_power_control
`default_nettype wire

// File: design/rtc_pwr_pkg.sv
// constants shared by the backup power control block
package rtc_pwr_pkg;
    // clock and timebase
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned SEC_MS        = 1000;
    // register offsets
    localparam logic [7:0] ADDR_FLAG = 8'h0e;
    localparam logic [7:0] ADDR_CTRL = 8'h0f;
    localparam logic [7:0] ADDR_BKUP = 8'h18;
    // flag register fields
    localparam int unsigned FLAG_UPD  = 5;
    localparam int unsigned FLAG_TMR  = 4;
    localparam int unsigned FLAG_ALM  = 3;
    localparam int unsigned FLAG_DROP = 0;
    // control register fields
    localparam int unsigned CTRL_CSEL = 6;
    localparam int unsigned CTRL_UIE  = 5;
    localparam int unsigned CTRL_TIE  = 4;
    localparam int unsigned CTRL_AIE  = 3;
    localparam int unsigned CTRL_RST  = 0;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam logic [7:0] CTRL_WMASK = 8'hf9;
    // backup function register fields
    localparam int unsigned BK_DDIS  = 3;
    localparam int unsigned BK_SWITCH_FORCE_OFF = 2;
    localparam int unsigned BK_SMP   = 0;
    localparam logic [7:0] BK_RESET = 8'h00;
    localparam logic [7:0] BK_WMASK = 8'h0f;
    // compensation intervals, in ms
    localparam int unsigned COMP_T0_MS = 500;
    localparam int unsigned COMP_T1_MS = 2000;
    localparam int unsigned COMP_T2_MS = 10000;
    localparam int unsigned COMP_T3_MS = 30000;
    // monitor windows, in ms
    localparam int unsigned SMP_T0_MS = 2;
    localparam int unsigned SMP_T1_MS = 16;
    localparam int unsigned SMP_T2_MS = 128;
    localparam int unsigned SMP_T3_MS = 256;

    typedef enum logic {ST_BACKUP, ST_NORMAL} pwr_state_e;
endpackage : rtc_pwr_pkg

// File: design/ms_timebase.sv
// millisecond and one-second ticks from the oscillator clock
`timescale 1ns/1ps
`default_nettype none
module ms_timebase
    import rtc_pwr_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = MS_CYCLES
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    output logic      ms_tick,
    output logic      sec_tick
);
    localparam int unsigned CW = $clog2(CYC_PER_MS + 1);
    localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_MS - 1);
    localparam logic [9:0]    MS_LAST  = 10'(SEC_MS - 1);

    logic [CW-1:0] cyc_q;
    logic [9:0]    ms_q;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cyc_q   <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (cyc_q == CYC_LAST);
            cyc_q   <= (cyc_q == CYC_LAST) ? '0 : cyc_q + 1'b1;
        end
    end

    // first second tick lands one second after reset release
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ms_q     <= '0;
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= ms_tick && (ms_q == MS_LAST);
            if (ms_tick) begin
                ms_q <= (ms_q == MS_LAST) ? '0 : ms_q + 1'b1;
            end
        end
    end
endmodule : ms_timebase
`default_nettype wire

// File: tb/supply_host_model.sv
// far-side model: main supply and compensation-threshold comparators
`timescale 1ns/1ps
`default_nettype none
module supply_host_model (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic monitor_on_q,
    input  wire logic supply_up,
    input  wire logic above_comp,
    output logic      main_supply_detector,
    output logic      comp_threshold_voltage
);
    logic junk_q;

    // comparator without its enable gives no stable level
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            junk_q <= 1'b0;
        end else begin
            junk_q <= ~junk_q;
        end
    end

    assign main_supply_detector   = monitor_on_q ? supply_up : junk_q;
    assign comp_threshold_voltage = above_comp;
endmodule : supply_host_model
`default_nettype wire

// File: tb/rtc_backup_power_control_tb_top.sv
// self-checking bench for the backup power control block
`timescale 1ns/1ps
`default_nettype none
module rtc_backup_power_control_tb_top
    import rtc_pwr_pkg::*;
;
    localparam int CYC = 4;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } row_s;
    logic       mclk;
    logic       reset_n;
    logic       supply_up;
    logic       above_comp;
    logic [2:0] ev;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic [7:0] reg_wdata;
    logic       main_supply_detector;
    logic       comp_threshold_voltage;
    logic [7:0] reg_rdata_q;
    logic       monitor_on_q;
    logic       supply_switch_on_q;
    logic       normal_state_q;
    logic       serial_if_enable_q;
    logic       freq_out_enable_q;
    logic       comp_run_q;
    logic       int_n_o_q;
    logic       int_n_oe_q;
    int         n_mismatch;
    int         compares;
    int         cnt;
    logic       ok;
    logic [7:0] rv;
    logic [7:0] ef;
    row_s       rows [6];
    int         fb [3];
    int         comp_ms [2];

    rtc_backup_power_control #(.CYC_PER_MS(CYC)) dut_u (
        .mclk(mclk), .reset_n(reset_n),
        .main_supply_detector(main_supply_detector),
        .comp_threshold_voltage(comp_threshold_voltage),
        .timer_event(ev[0]), .alarm_event(ev[1]), .update_event(ev[2]),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .monitor_on_q(monitor_on_q),
        .supply_switch_on_q(supply_switch_on_q),
        .normal_state_q(normal_state_q),
        .serial_if_enable_q(serial_if_enable_q),
        .freq_out_enable_q(freq_out_enable_q), .comp_run_q(comp_run_q),
        .int_n_o_q(int_n_o_q), .int_n_oe_q(int_n_oe_q)
    );

    supply_host_model sh_u (
        .mclk(mclk), .reset_n(reset_n), .monitor_on_q(monitor_on_q),
        .supply_up(supply_up), .above_comp(above_comp),
        .main_supply_detector(main_supply_detector),
        .comp_threshold_voltage(comp_threshold_voltage)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic near(input int got, input int exp, input int tol);
        compares++;
        if (got < exp - tol || got > exp + tol) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : near

    function automatic logic sig(input int w);
        case (w)
            0: return monitor_on_q;
            1: return normal_state_q;
            2: return comp_run_q;
            3: return int_n_oe_q;
            default: return supply_switch_on_q;
        endcase
    endfunction : sig

    // cnt ends as the number of edges waited
    task automatic wait_until(input int w, input logic v, input int lim,
                              input bit must);
        cnt = 0;
        ok = (sig(w) === v);
        while (!ok && cnt < lim) begin
            @(posedge mclk);
            #1;
            cnt++;
            ok = (sig(w) === v);
        end
        if (must && !ok) begin
            n_mismatch++;
            stop_test();
        end
    endtask : wait_until

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        repeat (2) @(posedge mclk);
        #1;
        rv = reg_rdata_q;
    endtask : rd

    task automatic pulse(input int i);
        @(posedge mclk);
        ev[i] <= 1'b1;
        @(posedge mclk);
        ev[i] <= 1'b0;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        #300us;
        n_mismatch++;
        stop_test();
    end

    initial begin
        reset_n = 1'b0;
        supply_up = 1'b0;
        above_comp = 1'b1;
        ev = 3'h0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        n_mismatch = 0;
        compares = 0;
        fb = '{FLAG_TMR, FLAG_ALM, FLAG_UPD};
        comp_ms = '{COMP_T0_MS, COMP_T1_MS};
        rows = '{'{ADDR_CTRL, 8'hff, CTRL_WMASK}, '{ADDR_CTRL, 8'h38, 8'h38},
                 '{ADDR_BKUP, 8'hf0, 8'h00}, '{ADDR_BKUP, 8'h01, 8'h01},
                 '{8'h20, 8'h55, 8'h00}, '{ADDR_FLAG, 8'hff, 8'h00}};
        repeat (5) @(posedge mclk);
        #1;
        chk({2'h0, normal_state_q, supply_switch_on_q, serial_if_enable_q,
             freq_out_enable_q, int_n_oe_q, monitor_on_q}, 8'h00);
        @(posedge mclk);
        reset_n   <= 1'b1;
        supply_up <= 1'b1;
        wait_until(0, 1'b1, 4100, 1);
        near(cnt, 1000 * CYC, 4);
        chk({7'h0, supply_switch_on_q}, 8'h00);
        wait_until(0, 1'b0, 300, 1);
        near(cnt, SMP_T0_MS * CYC, 1);
        wait_until(1, 1'b1, 4, 1);
        wait_until(4, 1'b1, 4, 1);
        chk({6'h0, serial_if_enable_q, freq_out_enable_q}, 8'h03);
        rd(ADDR_CTRL);
        chk(rv, CTRL_RESET);
        rd(ADDR_BKUP);
        chk(rv, BK_RESET);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr);
            chk(rv, rows[i].exp);
        end
        // each source alone, all enables on
        for (int i = 0; i < 3; i++) begin
            ef = 8'h00;
            ef[fb[i]] = 1'b1;
            pulse(i);
            wait_until(3, 1'b1, 4, 1);
            chk({7'h0, int_n_o_q}, 8'h00);
            rd(ADDR_FLAG);
            chk(rv, ef);
            wr(ADDR_FLAG, 8'h00);
            wait_until(3, 1'b0, 4, 1);
        end
        wr(ADDR_CTRL, 8'h00);
        pulse(0);
        wait_until(3, 1'b1, 4, 0);
        chk({7'h0, ok}, 8'h00);
        wr(ADDR_FLAG, 8'h00);
        // gap between two runs, timed from the first run seen
        for (int c = 0; c < 2; c++) begin
            wr(ADDR_CTRL, {c[1:0], 6'h00});
            wait_until(2, 1'b1, 9000, 1);
            repeat (2) @(posedge mclk);
            wait_until(2, 1'b1, 9000, 1);
            near(cnt + 2, comp_ms[c] * CYC, 1);
        end
        wr(ADDR_CTRL, 8'h10);
        @(posedge mclk);
        above_comp <= 1'b0;
        wait_until(2, 1'b1, 2500, 0);
        chk({7'h0, ok}, 8'h00);
        rd(ADDR_FLAG);
        chk(rv, 8'h01 << FLAG_DROP);
        @(posedge mclk);
        above_comp <= 1'b1;
        wait_until(2, 1'b1, 2100, 1);
        wr(ADDR_FLAG, 8'h00);
        wr(ADDR_BKUP, 8'h08);
        repeat (80) @(posedge mclk);
        wait_until(0, 1'b1, 4300, 0);
        chk({6'h0, ok, supply_switch_on_q}, 8'h01);
        wr(ADDR_BKUP, 8'h0c);
        repeat (3) @(posedge mclk);
        #1;
        chk({7'h0, supply_switch_on_q}, 8'h00);
        wr(ADDR_BKUP, 8'h01);
        repeat (80) @(posedge mclk);
        wait_until(0, 1'b1, 4300, 1);
        chk({7'h0, supply_switch_on_q}, 8'h00);
        wait_until(0, 1'b0, 300, 1);
        near(cnt, SMP_T1_MS * CYC, 1);
        @(posedge mclk);
        supply_up <= 1'b0;
        repeat (10) @(posedge mclk);
        #1;
        chk({6'h0, normal_state_q, supply_switch_on_q}, 8'h03);
        wait_until(1, 1'b0, 4300, 1);
        repeat (2) @(posedge mclk);
        #1;
        chk({4'h0, serial_if_enable_q, freq_out_enable_q, supply_switch_on_q,
             int_n_oe_q}, 8'h00);
        pulse(0);
        wait_until(3, 1'b1, 4, 0);
        chk({7'h0, ok}, 8'h00);
        wait_until(0, 1'b1, 4300, 1);
        chk({7'h0, supply_switch_on_q}, 8'h00);
        @(posedge mclk);
        supply_up <= 1'b1;
        wait_until(1, 1'b1, 4400, 1);
        // timer flag caught in backup now drives the pin
        wait_until(3, 1'b1, 8, 1);
        stop_test();
    end
endmodule : rtc_backup_power_control_tb_top
`default_nettype wire
